// >>> clk_pulse_gen.sv
// clock generator end: control register, divider, bus master clock select
//
// The address map and the APB interface to the registers were left to the implementer.
`timescale 1ns/100ps
module clk_pulse_gen
  import clk_sel_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // register link from the controller
  clk_sel_link.dev link,
  // operating mode from the chip mode logic
  input wire logic hiz_mode,
  // clock outputs, as one-cycle ticks on pclk, and the select in force
  output logic sys_clk_tick,
  output logic bus_clk_tick,
  output logic [DIV_TAPS-1:0] periph_tick,
  output logic [SEL_W-1:0] active_select,
  // clock output pin
  output logic phi_gate,
  output logic phi_pin_o,
  output logic phi_pin_oe
);

  logic [REG_W-1:0] system_clock_control;
  logic [4:0] div_count;
  logic [SEL_W-1:0] sel_now;
  logic [SEL_W-1:0] sel_req;
  logic sel_legal;
  logic at_boundary;
  logic next_bus_tick;
  logic [DIV_TAPS-1:0] next_periph;

  // tap mask: low s bits set, so tap s fires once every 2**s cycles
  function automatic logic [4:0] tap_mask(input logic [SEL_W-1:0] s);
    logic [4:0] m;
    m = 5'h00;
    for (int i = 0; i < 5; i++)
    begin
      if (i < int'(s))
      begin
        m[i] = 1'b1;
      end
    end
    return m;
  endfunction : tap_mask

  assign sel_req = system_clock_control[SEL_LSB +: SEL_W];
  // a prohibited code never reaches the selector
  assign sel_legal = (sel_req[2:1] != SEL_BAD_HI);
  // every tap completes its period when the counter wraps
  assign at_boundary = (div_count == DIV_WRAP);

  // register write; bits 5 and 4 are not stored
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      system_clock_control <= SCC_RESET;
    end
    else if (link.req && link.we)
    begin
      system_clock_control <= link.wdata & SCC_WMASK;
    end
  end

  // read data mirrors the register every cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      link.rdata <= SCC_RESET;
    end
    else
    begin
      link.rdata <= system_clock_control & SCC_WMASK;
    end
  end

  // one acknowledge per request, one cycle later
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      link.ack <= 1'b0;
    end
    else
    begin
      link.ack <= link.req;
    end
  end

  // free-running medium-speed divider on the system clock
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      div_count <= 5'h00;
    end
    else
    begin
      div_count <= div_count + 5'h01;
    end
  end

  // adopt a new select only at the common wrap point, so no
  // shortened bus clock period can occur across a change
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sel_now <= SEL_FULL;
    end
    else if (at_boundary && sel_legal)
    begin
      sel_now <= sel_req;
    end
  end

  // tick decode for the selected tap and all peripheral taps
  always_comb
  begin
    next_bus_tick = ((div_count & tap_mask(sel_now))
                    == tap_mask(sel_now));
    for (int t = 0; t < DIV_TAPS; t++)
    begin
      next_periph[t] = ((div_count & tap_mask(SEL_W'(t + 1)))
                       == tap_mask(SEL_W'(t + 1)));
    end
  end

  // system clock tick: every cycle once out of reset
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sys_clk_tick <= 1'b0;
    end
    else
    begin
      sys_clk_tick <= 1'b1;
    end
  end

  // bus master clock tick from the selected tap
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      bus_clk_tick <= 1'b0;
    end
    else
    begin
      bus_clk_tick <= next_bus_tick;
    end
  end

  // peripheral ticks, one per divider tap, always running
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      periph_tick <= '0;
    end
    else
    begin
      periph_tick <= next_periph;
    end
  end

  // select in force, registered so it lines up with the ticks
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      active_select <= SEL_FULL;
    end
    else
    begin
      active_select <= sel_now;
    end
  end

  // clock output pin: gate open only while the stop bit is clear;
  // level high when driven, released in the high-impedance mode
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      phi_gate <= 1'b0;
      phi_pin_o <= 1'b1;
      phi_pin_oe <= 1'b0;
    end
    else
    begin
      phi_gate <= !system_clock_control[STOP_BIT]
                  && !hiz_mode;
      phi_pin_o <= 1'b1;
      phi_pin_oe <= !hiz_mode;
    end
  end

endmodule : clk_pulse_gen

// >>> clk_sel_ctrl.sv
// controller end: apb registers that drive the clock control register
`timescale 1ns/100ps
module clk_sel_ctrl
  import clk_sel_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // link to the clock generator
  clk_sel_link.ctl link,
  // low-power entry handshake
  output logic standby_ready
);

  logic [7:0] wanted;
  logic pending;
  logic busy;
  logic rejected;
  logic lp_req;
  logic [7:0] mirror;
  logic setup;
  logic wr_ctrl;
  logic wr_stat;
  logic wr_lp;
  logic [7:0] next_wanted;
  logic bad_code;
  logic ack_d;

  assign setup = psel && !penable;
  assign wr_ctrl = psel && penable && pwrite && (paddr == OFS_CONTROL);
  assign wr_stat = psel && penable && pwrite && (paddr == OFS_STATUS);
  assign wr_lp = psel && penable && pwrite && (paddr == OFS_LOWPOWER);
  // reserved bits 6 and 3 forced to zero on every write
  assign next_wanted = pwdata[7:0] & ~SCC_MUSTZERO;
  assign bad_code = (next_wanted[2:1] == SEL_BAD_HI);

  // requested value and pending write; prohibited codes are refused
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wanted <= SCC_RESET;
      pending <= 1'b0;
    end
    else if (wr_ctrl && !bad_code)
    begin
      wanted <= next_wanted;
      pending <= 1'b1;
    end
    else if (wr_lp && pwdata[LP_REQ_BIT])
    begin
      wanted <= {wanted[7:3], SEL_FULL};
      pending <= 1'b1;
    end
    else if (link.req)
    begin
      pending <= 1'b0; // handed over once the request goes out
    end
  end

  // link requests: one-cycle pulse; busy holds until the mirror has
  // taken the new register value, so status never shows stale data
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      link.req <= 1'b0;
      link.we <= 1'b0;
      link.wdata <= SCC_RESET;
      ack_d <= 1'b0;
      busy <= 1'b0;
    end
    else
    begin
      link.req <= pending && !busy && !link.req;
      link.we <= pending && !busy && !link.req;
      link.wdata <= wanted;
      ack_d <= link.ack;
      // delayed ack: rdata is new and lands in the mirror this edge
      if (link.req)
      begin
        busy <= 1'b1;
      end
      else if (ack_d)
      begin
        busy <= 1'b0;
      end
    end
  end

  // mirror of the device register, reject flag, low-power request
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mirror <= SCC_RESET;
      rejected <= 1'b0;
      lp_req <= 1'b0;
      standby_ready <= 1'b0;
    end
    else
    begin
      mirror <= link.rdata;
      // set wins over a clear in the same cycle
      if (wr_ctrl && bad_code)
      begin
        rejected <= 1'b1;
      end
      else if (wr_stat && pwdata[STAT_REJ_BIT])
      begin
        rejected <= 1'b0;
      end
      if (wr_lp)
      begin
        lp_req <= pwdata[LP_REQ_BIT];
      end
      standby_ready <= lp_req && !pending && !busy
                       && (mirror[2:0] == SEL_FULL);
    end
  end

  // apb answer: data prepared in setup, zero wait states
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= 1'b1;
      if (setup)
      begin
        pslverr <= !(paddr == OFS_CONTROL || paddr == OFS_STATUS
                     || paddr == OFS_LOWPOWER);
        unique case (paddr)
          OFS_CONTROL: prdata <= {24'h000000, wanted};
          OFS_STATUS: prdata <= {22'h000000, rejected,
                                 pending || busy, mirror};
          OFS_LOWPOWER: prdata <= {30'h00000000, standby_ready, lp_req};
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule : clk_sel_ctrl

// >>> clk_sel_link.sv
// register link between the clock generator and its controller
`timescale 1ns/100ps
interface clk_sel_link;
  logic req;
  logic we;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic ack;

  modport dev (
    input req,
    input we,
    input wdata,
    output rdata,
    output ack
  );

  modport ctl (
    output req,
    output we,
    output wdata,
    input rdata,
    input ack
  );
endinterface : clk_sel_link

// >>> clk_sel_pkg.sv
// shared constants for the bus master clock selection block
package clk_sel_pkg;

  // register width and field positions of system_clock_control
  localparam int REG_W = 8;
  localparam int STOP_BIT = 7;
  localparam int RSV6_BIT = 6;
  localparam int RSV3_BIT = 3;
  localparam int SEL_LSB = 0;
  localparam int SEL_W = 3;

  // value after reset and writable-bit mask (bits 5 and 4 stay zero)
  localparam logic [7:0] SCC_RESET = 8'h00;
  localparam logic [7:0] SCC_WMASK = 8'hCF;
  // bits software must leave at zero: 6, 3
  localparam logic [7:0] SCC_MUSTZERO = 8'h48;

  // select codes
  localparam logic [2:0] SEL_FULL = 3'h0;
  localparam logic [2:0] SEL_DIV32 = 3'h5;
  localparam logic [1:0] SEL_BAD_HI = 2'h3;

  // divider: five medium-speed taps, counter spans the longest period
  localparam int DIV_TAPS = 5;
  localparam logic [4:0] DIV_WRAP = 5'h1F;

  // controller apb map
  localparam logic [7:0] OFS_CONTROL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_LOWPOWER = 8'h08;
  localparam int STAT_BUSY_BIT = 8;
  localparam int STAT_REJ_BIT = 9;
  localparam int LP_REQ_BIT = 0;
  localparam int LP_READY_BIT = 1;

endpackage : clk_sel_pkg

// >>> clk_sel_properties.sv
// link checker for the clock select register path
`timescale 1ns/100ps
module clk_sel_properties
  import clk_sel_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // link
  input wire logic req,
  input wire logic we,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic ack
);
  // single domain, clock and reset given once
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // handshake shape
  a_ack_one: assert property (req |=> ack ##1 !ack)
    else $error("ack not one cycle");
  a_ack_cause: assert property (ack |-> $past(req))
    else $error("ack without req");
  a_req_gap: assert property (req |=> !req)
    else $error("req too soon");
  // register follows writes, masked
  a_reg_load: assert property (req && we |=> ##1
    rdata == ($past(wdata, 2) & SCC_WMASK))
    else $error("bad register load");
  a_reg_hold: assert property (!$past(ack) |-> $stable(rdata))
    else $error("register moved");
  a_rsvd_zero: assert property (rdata[5:4] == 2'h0)
    else $error("reserved bits set");
  a_no_bad_sel: assert property (rdata[2:1] != SEL_BAD_HI)
    else $error("prohibited select");
  // controller never sends the must-be-zero bits
  a_must_zero: assert property (req |->
    (wdata & SCC_MUSTZERO) == 8'h00)
    else $error("must-zero bit sent");
endmodule : clk_sel_properties

// >>> tb_bus_master_clock_select.sv
// self-checking bench for the clock select pair
`timescale 1ns/100ps
module tb_bus_master_clock_select
  import clk_sel_pkg::*;
;
  // bus and generator signals
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic hiz_mode, sys_clk_tick, bus_clk_tick, phi_gate, phi_pin_o;
  logic phi_pin_oe, standby_ready;
  logic [4:0] periph_tick;
  logic [2:0] active_select;
  int err_total, tests_run;
  clk_sel_link lk();

  clk_pulse_gen clk_pulse_gen_i (.pclk, .presetn, .link(lk), .hiz_mode,
    .sys_clk_tick, .bus_clk_tick, .periph_tick, .active_select,
    .phi_gate, .phi_pin_o, .phi_pin_oe);
  clk_sel_ctrl clk_sel_ctrl_i (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .link(lk),
    .standby_ready);
  clk_sel_properties clk_sel_properties_i (.pclk, .presetn,
    .req(lk.req), .we(lk.we), .wdata(lk.wdata), .rdata(lk.rdata),
    .ack(lk.ack));

  // 100 MHz clock
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e)
    begin
      err_total++;
      $display("mismatch at %0t: got %h want %h", $time, s, e);
    end
  endtask : chk

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : tally_and_finish

  // a wait that ran out ends the run
  task automatic lim(input logic stuck);
    if (stuck)
    begin
      err_total++;
      tally_and_finish;
    end
  endtask : lim

  // one apb transfer, held until pready; result in rd and er
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    lim(pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // poll status until the link write has landed
  task automatic settle;
    int n;
    n = 0;
    do
    begin
      apb(1'b0, OFS_STATUS, 32'h0);
      n++;
    end while (rd[STAT_BUSY_BIT] !== 1'b0 && n < 50);
    lim(rd[STAT_BUSY_BIT] !== 1'b0);
  endtask : settle

  // wait for select s, then count ticks in 64 cycles
  task automatic ticks(input logic [2:0] s);
    int n, b;
    int p[5];
    logic [5:0] pv;
    n = 0;
    pv = 6'h00;
    while (active_select !== s && n < 50)
    begin
      pv = {bus_clk_tick, periph_tick};
      @(posedge pclk);
      n++;
    end
    lim(active_select !== s);
    // the cycle before a switch closes every divider period
    if (n > 0)
      chk(pv, 6'h3F);
    b = 0;
    p = '{default: 0};
    repeat (64)
    begin
      @(posedge pclk);
      b += bus_clk_tick;
      for (int t = 0; t < 5; t++) p[t] += periph_tick[t];
    end
    chk(b, 64 >> s);
    for (int t = 0; t < 5; t++) chk(p[t], 64 >> (t + 1));
  endtask : ticks

  // main sequence
  initial
  begin
    {presetn, psel, penable, pwrite, hiz_mode} = 5'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    err_total = 0;
    tests_run = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(rd[9:0], {2'h0, SCC_RESET});
    chk(er, 1'b0);
    chk(standby_ready, 1'b0);
    // every legal code, each switch on a divider boundary
    for (int s = 0; s < 6; s++)
    begin
      apb(1'b1, OFS_CONTROL, 32'(s));
      settle;
      chk(rd[7:0], 8'(s));
      ticks(s[2:0]);
      chk(sys_clk_tick, 1'b1);
    end
    // both prohibited codes must leave the select alone
    for (int c = 6; c < 8; c++)
    begin
      apb(1'b1, OFS_CONTROL, 32'(c));
      repeat (40) @(posedge pclk);
      apb(1'b0, OFS_STATUS, 32'h0);
      chk(rd[9:0], 10'h205);
      chk(active_select, SEL_DIV32);
    end
    // writing one to the reject bit clears it
    apb(1'b1, OFS_STATUS, 32'h200);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(rd[9:0], 10'h005);
    // reserved bits written as ones, stop bit set
    apb(1'b1, OFS_CONTROL, 32'hFD);
    settle;
    chk(rd[7:0], 8'h85);
    chk(phi_gate, 1'b0);
    apb(1'b0, OFS_CONTROL, 32'h0);
    chk(rd[7:0], 8'hB5);
    // low-power entry forces full speed
    apb(1'b1, OFS_LOWPOWER, 32'h1);
    ticks(SEL_FULL);
    settle;
    chk(rd[2:0], SEL_FULL);
    chk(standby_ready, 1'b1);
    apb(1'b0, OFS_LOWPOWER, 32'h0);
    chk(rd[1:0], 2'h3);
    apb(1'b1, OFS_CONTROL, 32'h0);
    settle;
    chk(phi_gate, 1'b1);
    chk({phi_pin_o, phi_pin_oe}, 2'h3);
    hiz_mode <= 1'b1;
    apb(1'b0, 8'h0C, 32'h0);
    chk(er, 1'b1);
    chk({phi_pin_o, phi_pin_oe}, 2'h2);
    chk(phi_gate, 1'b0);
    tally_and_finish;
  end
endmodule : tb_bus_master_clock_select
